// >>> core/stb_pkg.sv
// Package for the system timebase: SFR offsets, reset values, widths.
// Assumes an 8-bit SFR bus with 8-bit addresses on the system clock.
package stb_pkg;
  // SFR addresses
  localparam logic [7:0] STB_SLOW_INTERVAL_ADDR = 8'hf9;
  localparam logic [7:0] STB_FAST_INTERVAL_ADDR = 8'hfa;
  localparam logic [7:0] STB_MICROSECOND_DIVIDER_DIV_ADDR      = 8'hfb;
  localparam logic [7:0] STB_MS_DIV_LOW_ADDR    = 8'hfc;
  localparam logic [7:0] STB_MS_DIV_HIGH_ADDR   = 8'hfd;
  localparam logic [7:0] STB_HMS_DIV_ADDR       = 8'hfe;
  // Reset values
  localparam logic [6:0] STB_INTERVAL_RST       = 7'h7f;
  localparam logic [5:0] STB_MICROSECOND_DIVIDER_DIV_RST       = 6'h03;
  localparam logic [7:0] STB_MS_DIV_LOW_RST     = 8'h9f;
  localparam logic [7:0] STB_MS_DIV_HIGH_RST    = 8'h0f;
  localparam logic [7:0] STB_HMS_DIV_RST        = 8'h63;
  // Field positions and widths
  localparam int         STB_LOAD_NOW_BIT       = 7;
  localparam int         STB_MICROSECOND_DIVIDER_W             = 6;
  localparam int         STB_MS_HIGH_SHIFT      = 8;
endpackage

// >>> core/stb_timebase.sv
// System timebase: microsecond, millisecond, hundred-ms prescalers and
// two reloadable interval counters with pending interrupt flags.
// Assumes a synchronous SFR port on the same clock; one access per cycle.
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - Microsecond tick divides clock by its divider plus one; resets 03h.
// RQ2 - Microsecond tick is the time unit for flash program timing.
// RQ3 - Millisecond tick period is high*256 plus low plus one clocks.
// RQ4 - Millisecond tick is the time unit for flash erase timing.
// RQ5 - Hundred-ms tick divides ms tick by divider plus one; resets 63h.
// RQ6 - Slow interval counts hundred-ms ticks, count plus one; resets 7Fh.
// RQ7 - Slow interrupt period spans 100 ms to 12.8 s at nominal settings.
// RQ8 - Reading the slow interval register clears its pending interrupt.
// RQ9 - Pending slow interrupt is visible as a status output for software.
// RQ10 - Bit 7 set reloads at once; clear defers the count until expiry.
// RQ11 - Load-now bit always reads back as zero.
// RQ12 - Fast interval counts ms ticks, period count plus one; resets 7Fh.
// RQ13 - Software clears fast interrupt by a read plus the aux flag clear; the code clears it on the read alone.
// RQ14 - On expiry each counter reloads, restarts and raises its request.
module stb_timebase (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // SFR access port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Ticks to flash timing and other users
  output logic            microsecond_divider_tick,
  output logic            ms_tick,
  output logic            hms_tick,
  // Pending interrupt requests
  output logic            slow_irq,
  output logic            fast_irq
);
  import stb_pkg::*;

  logic [5:0]  microsecond_divider_div_q;
  logic [7:0]  ms_lo_q, ms_hi_q, hms_div_q;
  logic [6:0]  slow_cnt_q, slow_rel_q, fast_cnt_q, fast_rel_q;
  logic [5:0]  microsecond_divider_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [7:0]  hms_cnt_q;
  logic        slow_irq_d, fast_irq_d;
  logic        wr_slow, wr_fast, rd_slow, rd_fast, now_bit;
  logic        ms_end, hms_end, slow_end, fast_end;

  assign wr_slow = sfr_wr && (sfr_addr == STB_SLOW_INTERVAL_ADDR);
  assign wr_fast = sfr_wr && (sfr_addr == STB_FAST_INTERVAL_ADDR);
  assign rd_slow = sfr_rd && (sfr_addr == STB_SLOW_INTERVAL_ADDR);
  assign rd_fast = sfr_rd && (sfr_addr == STB_FAST_INTERVAL_ADDR);
  assign now_bit = sfr_wdata[STB_LOAD_NOW_BIT];

  // Divider registers written by software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      microsecond_divider_div_q <= STB_MICROSECOND_DIVIDER_DIV_RST;
      ms_lo_q    <= STB_MS_DIV_LOW_RST;
      ms_hi_q    <= STB_MS_DIV_HIGH_RST;
      hms_div_q  <= STB_HMS_DIV_RST;
    end else if (sfr_wr) begin
      case (sfr_addr)
        STB_MICROSECOND_DIVIDER_DIV_ADDR:    microsecond_divider_div_q <= sfr_wdata[STB_MICROSECOND_DIVIDER_W-1:0];
        STB_MS_DIV_LOW_ADDR:  ms_lo_q    <= sfr_wdata;
        STB_MS_DIV_HIGH_ADDR: ms_hi_q    <= sfr_wdata;
        STB_HMS_DIV_ADDR:     hms_div_q  <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // Microsecond prescaler, one-cycle tick at terminal count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      microsecond_divider_cnt_q <= 6'h00;
      microsecond_divider_tick  <= 1'b0;
    end else if (microsecond_divider_cnt_q >= microsecond_divider_div_q) begin // [RQ1] [RQ2]
      microsecond_divider_cnt_q <= 6'h00;
      microsecond_divider_tick  <= 1'b1;
    end else begin
      microsecond_divider_cnt_q <= microsecond_divider_cnt_q + 6'h01;
      microsecond_divider_tick  <= 1'b0;
    end
  end

  // Millisecond prescaler over the 16-bit divider value
  assign ms_end = ms_cnt_q >= {ms_hi_q, ms_lo_q}; // [RQ3]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 16'h0000;
      ms_tick  <= 1'b0;
    end else begin
      ms_cnt_q <= ms_end ? 16'h0000 : ms_cnt_q + 16'h0001;
      ms_tick  <= ms_end; // [RQ4]
    end
  end

  // Hundred-ms prescaler counts ms ends
  assign hms_end = ms_end && (hms_cnt_q >= hms_div_q);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hms_cnt_q <= 8'h00;
      hms_tick  <= 1'b0;
    end else begin
      if (ms_end) begin
        hms_cnt_q <= hms_end ? 8'h00 : hms_cnt_q + 8'h01; // [RQ5]
      end
      hms_tick <= hms_end;
    end
  end

  // Slow interval counter; reload value and live count
  assign slow_end = hms_end && (slow_cnt_q == 7'h00);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slow_rel_q <= STB_INTERVAL_RST;
      slow_cnt_q <= STB_INTERVAL_RST;
    end else begin
      if (wr_slow) begin
        slow_rel_q <= sfr_wdata[6:0];
      end
      if (wr_slow && now_bit) begin
        slow_cnt_q <= sfr_wdata[6:0]; // [RQ10]
      end else if (slow_end) begin
        slow_cnt_q <= wr_slow ? sfr_wdata[6:0] : slow_rel_q; // [RQ14] [RQ6]
      end else if (hms_end) begin
        slow_cnt_q <= slow_cnt_q - 7'h01; // [RQ7]
      end
    end
  end

  // Fast interval counter counts ms ends
  assign fast_end = ms_end && (fast_cnt_q == 7'h00);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fast_rel_q <= STB_INTERVAL_RST;
      fast_cnt_q <= STB_INTERVAL_RST;
    end else begin
      if (wr_fast) begin
        fast_rel_q <= sfr_wdata[6:0];
      end
      if (wr_fast && now_bit) begin
        fast_cnt_q <= sfr_wdata[6:0]; // [RQ10]
      end else if (fast_end) begin
        fast_cnt_q <= wr_fast ? sfr_wdata[6:0] : fast_rel_q; // [RQ12] [RQ14]
      end else if (ms_end) begin
        fast_cnt_q <= fast_cnt_q - 7'h01;
      end
    end
  end

  // Pending flags: expiry wins over the clearing read
  assign slow_irq_d = slow_end | (slow_irq & ~rd_slow); // [RQ8]
  assign fast_irq_d = fast_end | (fast_irq & ~rd_fast); // [RQ13]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slow_irq <= 1'b0;
      fast_irq <= 1'b0;
    end else begin
      slow_irq <= slow_irq_d; // [RQ9]
      fast_irq <= fast_irq_d;
    end
  end

  // Registered read data, load-now bit reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        STB_SLOW_INTERVAL_ADDR: sfr_rdata <= {1'b0, slow_rel_q}; // [RQ11]
        STB_FAST_INTERVAL_ADDR: sfr_rdata <= {1'b0, fast_rel_q}; // [RQ11]
        STB_MICROSECOND_DIVIDER_DIV_ADDR:      sfr_rdata <= {2'b00, microsecond_divider_div_q};
        STB_MS_DIV_LOW_ADDR:    sfr_rdata <= ms_lo_q;
        STB_MS_DIV_HIGH_ADDR:   sfr_rdata <= ms_hi_q;
        STB_HMS_DIV_ADDR:       sfr_rdata <= hms_div_q;
        default:                sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  microsecond_divider_period_a: assert property (@(posedge clock) // [RQ1]
    disable iff (!rst_n)
    microsecond_divider_tick && microsecond_divider_div_q == 6'h01 && !sfr_wr |=> !microsecond_divider_tick ##1 microsecond_divider_tick)
    else $error("microsecond_divider tick period wrong");
  ms_tick_a: assert property (@(posedge clock) // [RQ3]
    disable iff (!rst_n)
    ms_end |=> ms_tick && ms_cnt_q == 16'h0000)
    else $error("ms tick not raised at terminal count");
  hms_sub_a: assert property (@(posedge clock) // [RQ5]
    disable iff (!rst_n)
    hms_tick |-> $past(ms_end))
    else $error("hundred-ms tick without ms tick");
  slow_set_a: assert property (@(posedge clock) // [RQ6]
    disable iff (!rst_n)
    slow_end |=> slow_irq)
    else $error("slow flag not set on expiry");
  slow_clr_a: assert property (@(posedge clock) // [RQ8]
    disable iff (!rst_n)
    rd_slow && !slow_end |=> !slow_irq)
    else $error("slow read did not clear flag");
  fast_set_a: assert property (@(posedge clock) // [RQ14]
    disable iff (!rst_n)
    fast_end && !wr_fast |=> fast_irq && fast_cnt_q == $past(fast_rel_q))
    else $error("fast reload or flag wrong");
  load_now_a: assert property (@(posedge clock) // [RQ10]
    disable iff (!rst_n)
    wr_slow && now_bit |=> slow_cnt_q == $past(sfr_wdata[6:0]))
    else $error("immediate load missed");
  read_zero_a: assert property (@(posedge clock) // [RQ11]
    disable iff (!rst_n)
    rd_fast |=> !sfr_rdata[7])
    else $error("load-now bit read as one");
  fast_hold_a: assert property (@(posedge clock) // [RQ12]
    disable iff (!rst_n)
    !ms_end && !wr_fast |=> $stable(fast_cnt_q))
    else $error("fast count moved without tick");
  // Slow flag meets its clearing read and drops one cycle later; fast flag rises after expiry; fast load-now write
  slow_irq_c: cover property (@(posedge clock) disable iff (!rst_n)
    slow_irq && rd_slow ##1 !slow_irq);
  fast_irq_c: cover property (@(posedge clock) disable iff (!rst_n)
    fast_end ##1 fast_irq);
  load_now_c: cover property (@(posedge clock) disable iff (!rst_n)
    wr_fast && now_bit);
endmodule

`default_nettype wire

// >>> bench/test_system_timebase_intervals.sv
// Testbench for the system timebase: SFR reads, writes and tick periods.
// Assumes stb_pkg and stb_timebase compiled first; 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_system_timebase_intervals;
  import stb_pkg::*;
  logic       clock, rst_n, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic       microsecond_divider_tick, ms_tick, hms_tick, slow_irq, fast_irq;
  logic [4:0] taps;
  logic [7:0] rst_tab [6];
  int         fail_count, n_checks;

  stb_timebase stb_timebase_inst (
    .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .microsecond_divider_tick(microsecond_divider_tick), .ms_tick(ms_tick), .hms_tick(hms_tick),
    .slow_irq(slow_irq), .fast_irq(fast_irq));

  // Outputs picked by index when measuring periods
  assign taps = {slow_irq, fast_irq, hms_tick, ms_tick, microsecond_divider_tick};

  // Free-running 4 ns clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe stands for one edge; an idle edge follows so that a next call
  // never raises the strobe in the step that lowered it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1;
    sfr_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Read data is registered, so it is sampled just after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1;
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
    @(posedge clock);
    #1;
  endtask

  // Counts cycles to the next rise of a tap; irq taps are cleared by a
  // read in the first counted cycle, so a stuck flag shows as one cycle
  task automatic period(input int sel, input int exp, input bit first);
    int n;
    n = 0;
    while (first && taps[sel] !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1;
      n++;
    end
    sfr_addr = (sel == 4) ? STB_SLOW_INTERVAL_ADDR : STB_FAST_INTERVAL_ADDR;
    sfr_rd = (sel > 2);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      if (n == 0) begin
        sfr_rd = 1'b0;
      end
      n++;
    end while (taps[sel] !== 1'b1 && n < 5000);
    chk(n, exp);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_tab = '{8'h7f, 8'h7f, 8'h03, 8'h9f, 8'h0f, 8'h63};
    rst_n = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'hf9 + 8'(i), rst_tab[i]);
    end
    wr(STB_MICROSECOND_DIVIDER_DIV_ADDR, 8'h05);
    period(0, 6, 1'b1);
    wr(STB_MICROSECOND_DIVIDER_DIV_ADDR, 8'h01);
    period(0, 2, 1'b1);
    wr(STB_MS_DIV_LOW_ADDR, 8'h09);
    wr(STB_MS_DIV_HIGH_ADDR, 8'h00);
    period(1, 10, 1'b1);
    wr(STB_HMS_DIV_ADDR, 8'h02);
    period(2, 30, 1'b1);
    wr(STB_FAST_INTERVAL_ADDR, 8'h82);
    rd(STB_FAST_INTERVAL_ADDR, 8'h02);
    period(3, 30, 1'b1);
    // Deferred count: the running count still expires after 30 cycles;
    // counting starts at the clearing read, three edges after the rise
    wr(STB_FAST_INTERVAL_ADDR, 8'h05);
    period(3, 28, 1'b0);
    period(3, 60, 1'b1);
    // Immediate load of zero expires at the very next ms tick, ten
    // cycles after the rise, counted from the read three edges later
    wr(STB_FAST_INTERVAL_ADDR, 8'h80);
    period(3, 8, 1'b0);
    wr(STB_SLOW_INTERVAL_ADDR, 8'h81);
    period(4, 60, 1'b1);
    rd(STB_SLOW_INTERVAL_ADDR, 8'h01);
    rd(8'hf8, 8'h00);
    tally_and_finish();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
